// [pcdcs_pkg.sv]
// package: constants for the device control and status register block
package pcdcs_pkg;
   // register map
   localparam logic [31:0] CSR_OFFSET     = 32'h0000_00C8;
   localparam logic [31:0] CSR_RESET      = 32'h0000_2000;
   localparam int          RSVD_MSB       = 31;
   localparam int          RSVD_LSB       = 22;
   // field positions
   localparam int          POS_PEND       = 21;
   localparam int          POS_AUX_SEEN   = 20;
   localparam int          POS_FLAG_LSB   = 16;
   localparam int          POS_FLAG_MSB   = 19;
   localparam int          POS_RETRY      = 15;
   localparam int          POS_MRRS_LSB   = 12;
   localparam int          POS_MRRS_MSB   = 14;
   localparam int          POS_NO_SNOOP   = 11;
   localparam int          POS_AUX_USE    = 10;
   localparam int          POS_PHANTOM    = 9;
   localparam int          POS_WIDE_TAG   = 8;
   localparam int          POS_MPS_LSB    = 5;
   localparam int          POS_MPS_MSB    = 7;
   localparam int          POS_RELAXED    = 4;
   localparam int          POS_EN_LSB     = 0;
   localparam int          POS_EN_MSB     = 3;
   // flag and enable order inside their nibbles
   localparam int          IDX_COR        = 0;
   localparam int          IDX_NONFATAL   = 1;
   localparam int          IDX_FATAL      = 2;
   localparam int          IDX_UR         = 3;
   localparam int          NUM_FLAGS      = 4;
   // field reset values and codes
   localparam logic [2:0]  MRRS_RESET     = 3'h2;
   localparam logic [2:0]  MRRS_MAX_CODE  = 3'h5;
   localparam logic [2:0]  MPS_RESET      = 3'h0;
   localparam logic [2:0]  MPS_CAPABILITY = 3'h0;
   localparam logic [12:0] MIN_TLP_BYTES  = 13'h0080;
   // ahb transfer type bit that marks NONSEQ or SEQ
   localparam int          HTRANS_ACTIVE  = 1;
endpackage

// [pcdcs_flag_bank.sv]
// sticky error detected flags, set by hardware, cleared by writing one
`timescale 1ns/100ps
module pcdcs_flag_bank #(
   parameter int N = 4
) (
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic [N-1:0] set_event,
   input  wire logic         clr_write,
   input  wire logic [N-1:0] clr_data,
   output logic      [N-1:0] flags_ff
);
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_flag
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               flags_ff[i] <= 1'b0;
            end else if (set_event[i]) begin
               // set beats a clear in the same cycle
               flags_ff[i] <= 1'b1;
            end else if (clr_write && clr_data[i]) begin
               // zero written leaves the flag alone
               flags_ff[i] <= 1'b0;
            end
         end
         AST_FLAG_SET: assert property (
            @(posedge hclk) disable iff (!hresetn)
            set_event[i] |=> flags_ff[i])
            else $error("error flag not set");
         AST_FLAG_HOLD: assert property (
            @(posedge hclk) disable iff (!hresetn)
            flags_ff[i] && !(clr_write && clr_data[i]) |=> flags_ff[i])
            else $error("error flag lost");
         AST_FLAG_CLEAR: assert property (
            @(posedge hclk) disable iff (!hresetn)
            clr_write && clr_data[i] && !set_event[i] |=> !flags_ff[i])
            else $error("error flag not cleared");
         AST_FLAG_ZERO_KEEP: assert property (
            @(posedge hclk) disable iff (!hresetn)
            clr_write && !clr_data[i] && flags_ff[i] |=> flags_ff[i])
            else $error("zero write cleared an error flag");
      end
   endgenerate
endmodule // pcdcs_flag_bank

// [pcdcs_dev_ctl_sts.sv]
// device control and status register with ahb-lite slave port
//
// Overview of operation
// - upper reserved bits read zero, writes ignored
// - pending bit shows outstanding non-posted requests
// - read-only bit shows aux power detected
// - unsupported request flag sticky, write one clears
// - fatal error flag sticky, write one clears
// - non-fatal error flag sticky, write one clears
// - correctable error flag sticky, write one clears
// - retry enable permits retry status answers
// - read request size codes, reset 512
// - no snoop enable reads zero, never set
// - aux power use enable permits extra draw
// - phantom function enable always reads zero
// - wide tag enable always reads zero
// - payload field writable, always means 128 bytes
// - relaxed ordering enable read-only zero
// - unsupported request reporting enable gates reports
// - fatal reporting enable gates fatal messages
// - non-fatal reporting enable gates non-fatal messages
// - correctable reporting enable gates correctable messages
// - payload capability is 128 bytes only
`timescale 1ns/100ps
module pcdcs_dev_ctl_sts #(
   parameter int PEND_W = 6
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   // core events
   input  wire logic        np_request_issued,
   input  wire logic        np_completion_received,
   input  wire logic        aux_supply_pin,
   input  wire logic        unsupported_request_event,
   input  wire logic        fatal_fault_event,
   input  wire logic        nonfatal_fault_event,
   input  wire logic        correctable_fault_event,
   // controls toward the core
   output logic             cfg_retry_enable,
   output logic      [12:0] max_read_request_bytes,
   output logic      [12:0] max_payload_bytes,
   output logic             aux_supply_use_enable,
   output logic             no_snoop_attr,
   output logic             relaxed_ordering_attr,
   output logic             unsupported_request_report,
   output logic             err_fatal_msg,
   output logic             err_nonfatal_msg,
   output logic             err_cor_msg,
   output logic             requests_outstanding,
   output logic             aux_supply_seen
);
   default clocking dcs_cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   ////////////////////////////////////////////////////////////////////////
   // bus front end
   logic        dp_wr_ff;
   logic        dp_rd_ff;
   logic        dp_hit_ff;
   logic        rd_done_ff;
   logic [31:0] hrdata_ff;
   logic        addr_take;
   logic        rd_finish;
   logic        wr_strobe;
   logic [31:0] csr_rd;

   // hsize is accepted as is: only whole-word transfers are expected
   assign addr_take = hsel && htrans[pcdcs_pkg::HTRANS_ACTIVE] && hready;
   // reads take one wait state so a write just before is visible
   assign hreadyout = !(dp_rd_ff && !rd_done_ff);
   assign rd_finish = dp_rd_ff && rd_done_ff && hready;
   assign wr_strobe = dp_wr_ff && dp_hit_ff && hready;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr_ff  <= 1'b0;
         dp_rd_ff  <= 1'b0;
         dp_hit_ff <= 1'b0;
      end else if (addr_take) begin
         dp_wr_ff  <= hwrite;
         dp_rd_ff  <= !hwrite;
         dp_hit_ff <= (haddr[31:2] == pcdcs_pkg::CSR_OFFSET[31:2]);
      end else if (hready) begin
         dp_wr_ff  <= 1'b0;
         dp_rd_ff  <= 1'b0;
         dp_hit_ff <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_done_ff <= 1'b0;
         hrdata_ff  <= 32'h0000_0000;
      end else if (dp_rd_ff && !rd_done_ff) begin
         rd_done_ff <= 1'b1;
         // unmapped addresses read zero
         hrdata_ff  <= dp_hit_ff ? csr_rd : 32'h0000_0000;
      end else if (rd_finish) begin
         rd_done_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // writable control fields
   logic       retry_en_ff;
   logic [2:0] mrrs_ff;
   logic       aux_use_ff;
   logic [2:0] mps_ff;
   logic [3:0] report_en_ff;
   logic [2:0] nxt_mrrs;

   assign nxt_mrrs = hwdata[pcdcs_pkg::POS_MRRS_MSB:pcdcs_pkg::POS_MRRS_LSB];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         retry_en_ff <= 1'b0;
      end else if (wr_strobe) begin
         retry_en_ff <= hwdata[pcdcs_pkg::POS_RETRY];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mrrs_ff <= pcdcs_pkg::MRRS_RESET;
      end else if (wr_strobe && nxt_mrrs <= pcdcs_pkg::MRRS_MAX_CODE) begin
         // reserved codes are dropped so the size stays meaningful
         mrrs_ff <= nxt_mrrs;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aux_use_ff <= 1'b0;
      end else if (wr_strobe) begin
         aux_use_ff <= hwdata[pcdcs_pkg::POS_AUX_USE];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mps_ff <= pcdcs_pkg::MPS_RESET;
      end else if (wr_strobe) begin
         // stored for readback only
         mps_ff <= hwdata[pcdcs_pkg::POS_MPS_MSB:pcdcs_pkg::POS_MPS_LSB];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         report_en_ff <= 4'h0;
      end else if (wr_strobe) begin
         report_en_ff <= hwdata[pcdcs_pkg::POS_EN_MSB:pcdcs_pkg::POS_EN_LSB];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sticky error flags
   logic [3:0] flag_set;
   logic [3:0] flags_ff;

   always_comb begin
      flag_set = 4'h0;
      // flags ignore the reporting enables
      flag_set[pcdcs_pkg::IDX_UR]       = unsupported_request_event;
      flag_set[pcdcs_pkg::IDX_FATAL]    = fatal_fault_event;
      flag_set[pcdcs_pkg::IDX_NONFATAL] = nonfatal_fault_event;
      flag_set[pcdcs_pkg::IDX_COR]      = correctable_fault_event;
   end

   pcdcs_flag_bank #(
      .N         (pcdcs_pkg::NUM_FLAGS)
   ) u_flags (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .set_event (flag_set),
      .clr_write (wr_strobe),
      .clr_data  (hwdata[pcdcs_pkg::POS_FLAG_MSB:pcdcs_pkg::POS_FLAG_LSB]),
      .flags_ff  (flags_ff)
   );

   ////////////////////////////////////////////////////////////////////////
   // outstanding non-posted requests
   logic [PEND_W-1:0] pend_cnt_ff;
   logic [PEND_W-1:0] nxt_pend_cnt;
   logic              pend_ff;

   always_comb begin
      nxt_pend_cnt = pend_cnt_ff;
      if (np_request_issued && !np_completion_received &&
          pend_cnt_ff != {PEND_W{1'b1}}) begin
         nxt_pend_cnt = pend_cnt_ff + {{(PEND_W-1){1'b0}}, 1'b1};
      end else if (np_completion_received && !np_request_issued &&
                   pend_cnt_ff != {PEND_W{1'b0}}) begin
         nxt_pend_cnt = pend_cnt_ff - {{(PEND_W-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend_cnt_ff <= {PEND_W{1'b0}};
         pend_ff     <= 1'b0;
      end else begin
         pend_cnt_ff <= nxt_pend_cnt;
         pend_ff     <= (nxt_pend_cnt != {PEND_W{1'b0}});
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // aux power detect pin, three-stage synchroniser
   logic aux_s1_ff;
   logic aux_s2_ff;
   logic aux_s3_ff;
   logic aux_seen_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aux_s1_ff <= 1'b0;
         aux_s2_ff <= 1'b0;
         aux_s3_ff <= 1'b0;
      end else begin
         aux_s1_ff <= aux_supply_pin;
         aux_s2_ff <= aux_s1_ff;
         aux_s3_ff <= aux_s2_ff;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aux_seen_ff <= 1'b0;
      end else if (aux_s2_ff == aux_s3_ff) begin
         aux_seen_ff <= aux_s3_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // error message requests, gated by reporting enables
   logic ur_rep_ff;
   logic fatal_msg_ff;
   logic nonfatal_msg_ff;
   logic cor_msg_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ur_rep_ff       <= 1'b0;
         fatal_msg_ff    <= 1'b0;
         nonfatal_msg_ff <= 1'b0;
         cor_msg_ff      <= 1'b0;
      end else begin
         ur_rep_ff       <= unsupported_request_event &&
                            report_en_ff[pcdcs_pkg::IDX_UR];
         fatal_msg_ff    <= fatal_fault_event &&
                            report_en_ff[pcdcs_pkg::IDX_FATAL];
         nonfatal_msg_ff <= nonfatal_fault_event &&
                            report_en_ff[pcdcs_pkg::IDX_NONFATAL];
         cor_msg_ff      <= correctable_fault_event &&
                            report_en_ff[pcdcs_pkg::IDX_COR];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // derived controls and readback
   logic [12:0] mrrs_bytes_ff;
   logic [12:0] mps_bytes_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mrrs_bytes_ff <= 13'h0000;
         mps_bytes_ff  <= 13'h0000;
      end else begin
         mrrs_bytes_ff <= 13'(pcdcs_pkg::MIN_TLP_BYTES << mrrs_ff);
         // capability allows only the smallest size, so every code
         // of the field maps to it
         mps_bytes_ff  <= 13'(pcdcs_pkg::MIN_TLP_BYTES <<
                              pcdcs_pkg::MPS_CAPABILITY);
      end
   end

   always_comb begin
      csr_rd = 32'h0000_0000; // reserved and hardwired bits
      csr_rd[pcdcs_pkg::POS_PEND]     = pend_ff;
      csr_rd[pcdcs_pkg::POS_AUX_SEEN] = aux_seen_ff;
      csr_rd[pcdcs_pkg::POS_FLAG_MSB:pcdcs_pkg::POS_FLAG_LSB] = flags_ff;
      csr_rd[pcdcs_pkg::POS_RETRY]    = retry_en_ff;
      csr_rd[pcdcs_pkg::POS_MRRS_MSB:pcdcs_pkg::POS_MRRS_LSB] = mrrs_ff;
      csr_rd[pcdcs_pkg::POS_NO_SNOOP] = 1'b0;
      csr_rd[pcdcs_pkg::POS_AUX_USE]  = aux_use_ff;
      csr_rd[pcdcs_pkg::POS_PHANTOM]  = 1'b0;
      csr_rd[pcdcs_pkg::POS_WIDE_TAG] = 1'b0;
      csr_rd[pcdcs_pkg::POS_MPS_MSB:pcdcs_pkg::POS_MPS_LSB] = mps_ff;
      csr_rd[pcdcs_pkg::POS_RELAXED]  = 1'b0;
      csr_rd[pcdcs_pkg::POS_EN_MSB:pcdcs_pkg::POS_EN_LSB] = report_en_ff;
   end

   assign cfg_retry_enable           = retry_en_ff;
   assign max_read_request_bytes     = mrrs_bytes_ff;
   assign max_payload_bytes          = mps_bytes_ff;
   assign aux_supply_use_enable      = aux_use_ff;
   assign no_snoop_attr              = 1'b0;
   assign relaxed_ordering_attr      = 1'b0;
   assign unsupported_request_report = ur_rep_ff;
   assign err_fatal_msg              = fatal_msg_ff;
   assign err_nonfatal_msg           = nonfatal_msg_ff;
   assign err_cor_msg                = cor_msg_ff;
   assign requests_outstanding       = pend_ff;
   assign aux_supply_seen            = aux_seen_ff;

   ////////////////////////////////////////////////////////////////////////
   // assertions
   AST_RSVD_ZERO: assert property (rd_finish && dp_hit_ff |->
      hrdata[pcdcs_pkg::RSVD_MSB:pcdcs_pkg::RSVD_LSB] == 10'h000)
      else $error("reserved bits read nonzero");
   AST_PEND_SET: assert property (np_request_issued &&
      !np_completion_received |=> requests_outstanding)
      else $error("pending bit not set after request");
   AST_AUX_SEEN: assert property (aux_supply_pin [*5] |->
      aux_supply_seen) else $error("aux power not reported");
   AST_SET_WINS: assert property (wr_strobe && fatal_fault_event &&
      hwdata[pcdcs_pkg::POS_FLAG_MSB:pcdcs_pkg::POS_FLAG_LSB] == 4'hF
      |=> flags_ff[pcdcs_pkg::IDX_FATAL] &&
      err_fatal_msg == $past(report_en_ff[pcdcs_pkg::IDX_FATAL]))
      else $error("clear beat a new fault");
   AST_RETRY_WR: assert property (wr_strobe |=>
      cfg_retry_enable == $past(hwdata[pcdcs_pkg::POS_RETRY]))
      else $error("retry enable not written");
   AST_MRRS_BYTES: assert property (wr_strobe &&
      hwdata[pcdcs_pkg::POS_MRRS_MSB:pcdcs_pkg::POS_MRRS_LSB] == 3'h5
      |-> ##2 max_read_request_bytes == 13'h1000)
      else $error("read request size mismatch");
   AST_AUX_USE: assert property (wr_strobe |=>
      aux_supply_use_enable == $past(hwdata[pcdcs_pkg::POS_AUX_USE]))
      else $error("aux use enable not written");
   AST_HARD_ZERO: assert property (rd_finish |->
      hrdata[11] == 1'b0 && hrdata[9:8] == 2'h0 && hrdata[4] == 1'b0)
      else $error("hardwired bit read one");
   AST_PAYLOAD: assert property ($past(hresetn) |->
      max_payload_bytes == 13'h0080)
      else $error("payload limit not 128 bytes");
   AST_MSG_GATE: assert property ((fatal_fault_event &&
      !report_en_ff[pcdcs_pkg::IDX_FATAL] |=> !err_fatal_msg) and
      (nonfatal_fault_event && report_en_ff[pcdcs_pkg::IDX_NONFATAL]
       |=> err_nonfatal_msg))
      else $error("fault message gating wrong");
   AST_COR_UR_GATE: assert property ((err_cor_msg |->
      $past(report_en_ff[pcdcs_pkg::IDX_COR])) and
      (unsupported_request_report |->
       $past(report_en_ff[pcdcs_pkg::IDX_UR])))
      else $error("report issued while disabled");
   AST_FLAG_NO_EN: assert property (correctable_fault_event &&
      !report_en_ff[pcdcs_pkg::IDX_COR]
      |=> flags_ff[pcdcs_pkg::IDX_COR] && !err_cor_msg)
      else $error("flag depends on report enable");
endmodule // pcdcs_dev_ctl_sts

// [pcdcs_dev_ctl_sts_test.sv]
// testbench: ahb-lite register access and event checks for the csr block
`timescale 1ns/100ps
module pcdcs_dev_ctl_sts_test;
   localparam logic [31:0] CSR = pcdcs_pkg::CSR_OFFSET;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic        hready;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic        np_req = 1'b0;
   logic        np_cmp = 1'b0;
   logic        aux_pin = 1'b0;
   logic [3:0]  ev = 4'h0;
   logic [3:0]  msg;
   logic        retry_en;
   logic [12:0] rd_bytes;
   logic [12:0] pay_bytes;
   logic        aux_use;
   logic        no_snoop;
   logic        relaxed;
   logic        pend;
   logic        aux_seen;
   int          failures = 0;
   int          total_checks = 0;
   logic [31:0] rd;

   assign hready = hreadyout;
   always #20 hclk = ~hclk;

   pcdcs_dev_ctl_sts i_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .np_request_issued(np_req),
      .np_completion_received(np_cmp), .aux_supply_pin(aux_pin),
      .unsupported_request_event(ev[3]), .fatal_fault_event(ev[2]),
      .nonfatal_fault_event(ev[1]), .correctable_fault_event(ev[0]),
      .cfg_retry_enable(retry_en), .max_read_request_bytes(rd_bytes),
      .max_payload_bytes(pay_bytes), .aux_supply_use_enable(aux_use),
      .no_snoop_attr(no_snoop), .relaxed_ordering_attr(relaxed),
      .unsupported_request_report(msg[3]), .err_fatal_msg(msg[2]),
      .err_nonfatal_msg(msg[1]), .err_cor_msg(msg[0]),
      .requests_outstanding(pend), .aux_supply_seen(aux_seen)
   );

   ////////////////////////////////////////////////////////////////////////
   task automatic check_word(input string what, input logic [31:0] exp,
                             input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic check_bit(input string what, input logic exp,
                            input logic got);
      check_word(what, {31'h0, exp}, {31'h0, got});
   endtask

   // bounded wait: a stuck hready must not hang the run
   task automatic bus_wait;
      int n;
      n = 0;
      @(posedge hclk);
      while (hready !== 1'b1 && n < 20) begin
         n++;
         @(posedge hclk);
      end
      // a stuck bus ends the run through the normal verdict
      if (hready !== 1'b1) begin
         check_bit("hready", 1'b1, hready);
         wrap_up;
      end
   endtask

   task automatic ahb_write(input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= 1'b1;
      htrans <= 2'h2;
      bus_wait;
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      bus_wait;
   endtask

   task automatic ahb_read(input logic [31:0] a, output logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= 1'b0;
      htrans <= 2'h2;
      bus_wait;
      htrans <= 2'h0;
      hsel <= 1'b0;
      bus_wait;
      d = hrdata;
   endtask

   task automatic check_reg(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] d;
      ahb_read(a, d);
      check_word("register", exp, d);
   endtask

   task automatic test_end(input string name);
      $display("test %s done, checks %0d, mismatches %0d", name,
               total_checks, failures);
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5000) @(posedge hclk);
      failures++;
      wrap_up;
   end

   initial begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      check_reg(CSR, 32'h0000_2000);
      check_word("payload", 32'h80, {19'h0, pay_bytes});
      check_word("read size", 32'h200, {19'h0, rd_bytes});
      check_bit("response", 1'b0, hresp);
      test_end("reset");
      // every writable and fixed bit at once; code 7 is refused
      ahb_write(CSR, 32'hFFFF_FFFF);
      check_reg(CSR, 32'h0000_A4EF);
      check_bit("retry", 1'b1, retry_en);
      check_bit("aux use", 1'b1, aux_use);
      check_bit("no snoop", 1'b0, no_snoop);
      check_bit("relaxed", 1'b0, relaxed);
      check_word("payload", 32'h80, {19'h0, pay_bytes});
      ahb_write(32'h0000_00CC, 32'hFFFF_FFFF);
      check_reg(32'h0000_00CC, 32'h0);
      check_reg(CSR, 32'h0000_A4EF);
      test_end("all ones");
      for (int c = 0; c < 6; c++) begin
         ahb_write(CSR, 32'(c) << 12);
         @(posedge hclk);
         #1;
         check_word("read size", 32'h80 << c, {19'h0, rd_bytes});
         check_bit("retry", 1'b0, retry_en);
         @(posedge hclk);
         check_reg(CSR, 32'(c) << 12);
      end
      for (int c = 6; c < 8; c++) begin
         ahb_write(CSR, 32'(c) << 12);
         check_reg(CSR, 32'h0000_5000);
      end
      test_end("read size");
      for (int i = 0; i < 4; i++) begin
         for (int e = 0; e < 2; e++) begin
            rd = 32'h2000 | (32'(e) << i);
            ahb_write(CSR, rd);
            ev <= 4'h1 << i;
            @(posedge hclk);
            ev <= 4'h0;
            #1;
            check_word("messages", {28'h0, 4'(e) << i}, {28'h0, msg});
            @(posedge hclk);
            check_reg(CSR, rd | (32'h1 << (16 + i)));
            ahb_write(CSR, rd);
            check_reg(CSR, rd | (32'h1 << (16 + i)));
            ahb_write(CSR, rd | (32'h1 << (16 + i)));
            check_reg(CSR, rd);
         end
      end
      test_end("flags");
      // events held through the clearing write must win
      ev <= 4'hF;
      ahb_write(CSR, 32'h000F_2000);
      ev <= 4'h0;
      check_reg(CSR, 32'h000F_2000);
      ahb_write(CSR, 32'h000F_2000);
      check_reg(CSR, 32'h0000_2000);
      test_end("set wins");
      np_req <= 1'b1;
      repeat (2) @(posedge hclk);
      np_req <= 1'b0;
      repeat (3) @(posedge hclk);
      check_reg(CSR, 32'h0020_2000);
      np_cmp <= 1'b1;
      @(posedge hclk);
      np_cmp <= 1'b0;
      repeat (3) @(posedge hclk);
      check_bit("pending", 1'b1, pend);
      np_cmp <= 1'b1;
      @(posedge hclk);
      np_cmp <= 1'b0;
      repeat (3) @(posedge hclk);
      check_bit("pending", 1'b0, pend);
      check_reg(CSR, 32'h0000_2000);
      test_end("pending");
      aux_pin <= 1'b1;
      repeat (12) @(posedge hclk);
      check_bit("aux seen", 1'b1, aux_seen);
      check_reg(CSR, 32'h0010_2000);
      aux_pin <= 1'b0;
      repeat (12) @(posedge hclk);
      check_bit("aux seen", 1'b0, aux_seen);
      check_reg(CSR, 32'h0000_2000);
      test_end("aux");
      wrap_up;
   end
endmodule // pcdcs_dev_ctl_sts_test
